// [shared/fis_cfg.svh]
// opcodes, status bit positions, id layout and suspend latency counts
`ifndef FIS_CFG_SVH
`define FIS_CFG_SVH

`define FIS_OP_QUAD_ID   8'h94
`define FIS_OP_IDENT     8'h9f
`define FIS_OP_SUSP_A    8'h75
`define FIS_OP_SUSP_B    8'hb0
`define FIS_OP_RES_A     8'h7a
`define FIS_OP_RES_B     8'h30
`define FIS_OP_WRITE_ENABLE_CMD      8'h06
`define FIS_OP_WRITE_DISABLE_CMD      8'h04
`define FIS_OP_PP        8'h02
`define FIS_OP_DPP       8'ha2
`define FIS_OP_QPP       8'h32
`define FIS_OP_READ      8'h03
`define FIS_OP_FREAD     8'h0b
`define FIS_OP_DUAL_OUTPUT_READ_CMD_O   8'h3b
`define FIS_OP_QUAD_OUTPUT_READ_CMD_O   8'h6b
`define FIS_OP_DUAL_OUTPUT_READ_CMD_IO  8'hbb
`define FIS_OP_QUAD_OUTPUT_READ_CMD_IO  8'heb
`define FIS_OP_PARAM     8'h5a
`define FIS_OP_ID_PAIR   8'h90
`define FIS_OP_ID_DUAL   8'h92
`define FIS_OP_SEC_READ  8'h48
`define FIS_OP_WRAP_SET  8'h77
`define FIS_OP_STAT_LO   8'h05
`define FIS_OP_STAT_HI   8'h35
`define FIS_OP_STAT_IRQ  8'h25
`define FIS_OP_RST_ARM   8'h66
`define FIS_OP_RST       8'h99
`define FIS_OP_NOP       8'h00

`define FIS_OPC_LAST     4'd7
`define FIS_QADDR_HI     4'd4
`define FIS_QADDR_LO     4'd5
`define FIS_QPRE_LAST    4'd11
`define FIS_ADDR_DEV_1ST 8'h01

`define FIS_SR_SUS_PGM   15
`define FIS_SR_SUS_ERS   10
`define FIS_SR_WEL       1
`define FIS_SR_WIP       0

`define FIS_CLK_NS       5
`define FIS_TPSL_NS      20000
`define FIS_TESL_NS      20000
`define FIS_TPSL_CYC     ((`FIS_TPSL_NS + `FIS_CLK_NS - 1) / `FIS_CLK_NS)
`define FIS_TESL_CYC     ((`FIS_TESL_NS + `FIS_CLK_NS - 1) / `FIS_CLK_NS)

`endif

// [shared/fis_pkg.sv]
// types shared by the id read and suspend control block
package fis_pkg;
    typedef enum logic [2:0] {
        OK_PAGE_PROG,
        OK_PAGE_ERASE,
        OK_SECTOR_ERASE,
        OK_HALF_ERASE,
        OK_BLOCK_ERASE,
        OK_OTHER
    } fis_op_kind_e;

    typedef enum logic [1:0] {PH_OPC, PH_QPRE, PH_OUT, PH_IGN} fis_phase_e;
    typedef enum logic [1:0] {SS_IDLE, SS_LAT, SS_HELD} fis_susp_e;

    typedef struct packed {
        logic [23:0] sh;
        logic [3:0]  dout;
        logic        quad;
    } fis_shift_s;

    typedef struct packed {
        logic         sck_s1;
        logic         sck_s2;
        logic         sck_d;
        logic         cs_s1;
        logic         cs_s2;
        logic [3:0]   io_s1;
        logic [3:0]   io_s2;
        fis_phase_e   phase;
        logic [3:0]   cnt;
        logic [7:0]   opc;
        logic [7:0]   qaddr;
        logic         id_quad;
        logic [3:0]   oe;
        fis_susp_e    st;
        logic [12:0]  lat;
        fis_op_kind_e skind;
        logic [23:0]  saddr;
        logic         sus_pgm;
        logic         sus_ers;
        logic         write_enable_latch;
        logic         write_in_progress;
        logic         nested;
        logic         sus_pulse;
        logic         res_pulse;
        logic         cmd_v;
        logic [7:0]   cmd;
        logic         rd_blk;
        logic         pg_ok;
    } fis_top_s;
endpackage

// [shared/fis_shift_if.sv]
// link between the command logic and the id shifter
interface fis_shift_if;
    logic        load;
    logic        quad;
    logic        step;
    logic [23:0] pattern;
    logic [3:0]  dout;

    modport ctrl    (output load, output quad, output step, output pattern, input dout);
    modport shifter (input load, input quad, input step, input pattern, output dout);
endinterface

// [verilog/fis_id_shift.sv]
// id shifter: rotates a loaded pattern out one bit or one nibble per step
module fis_id_shift (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    fis_shift_if.shifter sh
);
    import fis_pkg::*;

    fis_shift_s r;
    fis_shift_s n;

    always_comb begin
        n = r;
        if (sh.load) begin
            n.sh = sh.pattern;
            n.quad = sh.quad;
        end else if (sh.step) begin
            if (r.quad) begin
                // two bytes alternate forever, so only the top 16 bits rotate
                n.dout = r.sh[23:20];
                n.sh = {r.sh[19:8], r.sh[23:20], r.sh[7:0]};
            end else begin
                n.dout = {2'b00, r.sh[23], 1'b0};
                n.sh = {r.sh[22:0], r.sh[23]};
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sh.dout = r.dout;

    a_quad_nibble_msb: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        sh.step && !sh.load && r.quad |=> sh.dout == $past(r.sh[23:20]))
        else $error("quad id nibble not taken from the top of the pattern");
endmodule

// [verilog/fis_top.sv]
// serial flash id read commands and program/erase suspend control
// Contract
// - quad id pair read is taken only while the quad io enable bit is one
// - quad id read: opcode, then twelve quad nibbles of dummy, address, mode, dummy
// - id bytes leave msb first on falling edges; address 01h puts device first
// - quad id codes alternate for as long as chip select stays low
// - three byte ident read sends manufacturer, memory type, capacity on io1
// - three byte ident read is not decoded while a program or erase runs
// - raising chip select ends any id output and returns to standby
// - suspend opcodes stop a running page program or page, sector, block erase
// - while suspended, reads inside the suspended page or region are blocked
// - after the suspend latency the write enable latch clears and a flag sets
// - status bit 15 marks program suspend, bit 10 marks erase suspend
// - after the latency array reads, id reads, wrap set and resume are taken
// - write enable and page programs are taken in erase suspend only
// - disable, status reads, irq, reset and nop are taken at once after suspend
// - erase suspend programs only unprotected space outside the suspended region
// - a program inside an erase suspend cannot be suspended or resumed over
// - that program shows latch and busy as one, both clear when done
// - resume sets latch and busy, clears the flag and restarts the operation
`include "fis_cfg.svh"

module fis_top #(
    parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h16, // arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h40, // arbitrary value
    parameter logic [7:0] CAP_CODE = 8'h17  // arbitrary value
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  spi_sck_i,
    input  wire logic                  spi_cs_n_i,
    input  wire logic [3:0]            spi_io_i,
    output logic      [3:0]            spi_io_o,
    output logic      [3:0]            spi_io_oe_o,
    input  wire logic                  quad_io_enable_bit_i,
    input  wire logic                  op_running_i,
    input  wire fis_pkg::fis_op_kind_e op_kind_i,
    input  wire logic [23:0]           op_addr_i,
    input  wire logic                  op_done_i,
    input  wire logic [23:0]           array_read_addr_i,
    input  wire logic [23:0]           program_addr_i,
    input  wire logic                  program_protected_i,
    output logic                       op_suspend_o,
    output logic                       op_resume_o,
    output logic                       cmd_valid_o,
    output logic      [7:0]            cmd_code_o,
    output logic                       write_enable_latch_o,
    output logic                       write_in_progress_o,
    output logic                       program_suspended_flag_o,
    output logic                       erase_suspended_flag_o,
    output logic      [15:0]           status_word_o,
    output logic                       read_blocked_o,
    output logic                       program_permit_o
);
    import fis_pkg::*;

    fis_top_s    r;
    fis_top_s    n;
    logic [7:0]  opc8;
    logic        rise;
    logic        fall;
    logic [7:0]  first_id;
    logic [7:0]  second_id;

    fis_shift_if sh_if ();

    fis_id_shift i_fis_id_shift (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .sh      (sh_if.shifter)
    );

    // page, 4KB sector, 32KB half block and 64KB block compare on their upper bits
    function automatic logic region_hit(input fis_op_kind_e k,
                                        input logic [23:0]  a,
                                        input logic [23:0]  b);
        logic hit;
        hit = 1'b0;
        unique case (k)
            OK_PAGE_PROG,
            OK_PAGE_ERASE:   hit = (a[23:8] == b[23:8]);
            OK_SECTOR_ERASE: hit = (a[23:12] == b[23:12]);
            OK_HALF_ERASE:   hit = (a[23:15] == b[23:15]);
            OK_BLOCK_ERASE:  hit = (a[23:16] == b[23:16]);
            default:         hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [12:0] lat_last(input fis_op_kind_e k);
        if (k == OK_PAGE_PROG) begin
            return 13'(`FIS_TPSL_CYC - 1);
        end
        return 13'(`FIS_TESL_CYC - 1);
    endfunction

    function automatic logic cmd_allowed(input logic [7:0] op,
                                         input fis_susp_e  st,
                                         input logic       ers);
        logic no_wait;
        logic after_lat;
        logic wr;
        no_wait = op inside {`FIS_OP_WRITE_DISABLE_CMD, `FIS_OP_STAT_LO, `FIS_OP_STAT_HI,
                             `FIS_OP_STAT_IRQ, `FIS_OP_RST_ARM, `FIS_OP_RST, `FIS_OP_NOP};
        after_lat = op inside {`FIS_OP_READ, `FIS_OP_FREAD, `FIS_OP_DUAL_OUTPUT_READ_CMD_O,
                               `FIS_OP_QUAD_OUTPUT_READ_CMD_O, `FIS_OP_DUAL_OUTPUT_READ_CMD_IO, `FIS_OP_QUAD_OUTPUT_READ_CMD_IO,
                               `FIS_OP_PARAM, `FIS_OP_IDENT, `FIS_OP_ID_PAIR,
                               `FIS_OP_ID_DUAL, `FIS_OP_QUAD_ID, `FIS_OP_SEC_READ,
                               `FIS_OP_WRAP_SET, `FIS_OP_RES_A, `FIS_OP_RES_B};
        wr = op inside {`FIS_OP_WRITE_ENABLE_CMD, `FIS_OP_PP, `FIS_OP_DPP, `FIS_OP_QPP};
        return (st == SS_IDLE) | no_wait |
               ((st == SS_HELD) & (after_lat | (wr & ers)));
    endfunction

    assign opc8      = {r.opc[6:0], r.io_s2[0]};
    assign rise      = r.sck_s2 & ~r.sck_d;
    assign fall      = ~r.sck_s2 & r.sck_d;
    assign first_id  = (r.qaddr == `FIS_ADDR_DEV_1ST) ? DEV_CODE : MFR_CODE;
    assign second_id = (r.qaddr == `FIS_ADDR_DEV_1ST) ? MFR_CODE : DEV_CODE;

    always_comb begin
        n = r;
        n.sck_s1 = spi_sck_i;
        n.sck_s2 = r.sck_s1;
        n.sck_d = r.sck_s2;
        n.cs_s1 = spi_cs_n_i;
        n.cs_s2 = r.cs_s1;
        n.io_s1 = spi_io_i;
        n.io_s2 = r.io_s1;
        n.sus_pulse = 1'b0;
        n.res_pulse = 1'b0;
        n.cmd_v = 1'b0;
        sh_if.load = 1'b0;
        sh_if.quad = 1'b0;
        sh_if.step = 1'b0;
        sh_if.pattern = '0;

        // busy follows the array engine; a finished program drops the latch
        n.write_in_progress = op_running_i;
        if (op_done_i) begin
            n.write_enable_latch = 1'b0;
        end
        if (r.st == SS_HELD && r.sus_ers && op_running_i) begin
            n.nested = 1'b1;
        end else if (!op_running_i) begin
            n.nested = 1'b0;
        end

        if (r.st == SS_LAT) begin
            n.lat = 13'(r.lat + 13'd1);
            if (r.lat == lat_last(r.skind)) begin
                n.st = SS_HELD;
                n.write_enable_latch = 1'b0;
                n.sus_pgm = (r.skind == OK_PAGE_PROG);
                n.sus_ers = (r.skind != OK_PAGE_PROG);
            end
        end

        if (r.cs_s2) begin
            // deselect ends whatever was in flight, output included
            n.phase = PH_OPC;
            n.cnt = 4'd0;
            n.oe = 4'h0;
        end else begin
            unique case (r.phase)
                PH_OPC: begin
                    if (rise) begin
                        n.opc = opc8;
                        n.cnt = 4'(r.cnt + 4'd1);
                        if (r.cnt == `FIS_OPC_LAST) begin
                            n.cnt = 4'd0;
                            n.phase = PH_IGN;
                            if (cmd_allowed(opc8, r.st, r.sus_ers)) begin
                                n.cmd_v = 1'b1;
                                n.cmd = opc8;
                                if (opc8 == `FIS_OP_IDENT) begin
                                    if (!op_running_i) begin
                                        sh_if.load = 1'b1;
                                        sh_if.pattern = {MFR_CODE, MEM_TYPE, CAP_CODE};
                                        n.id_quad = 1'b0;
                                        n.phase = PH_OUT;
                                    end else begin
                                        n.cmd_v = 1'b0;
                                    end
                                end else if (opc8 == `FIS_OP_QUAD_ID) begin
                                    if (quad_io_enable_bit_i) begin
                                        n.phase = PH_QPRE;
                                    end else begin
                                        n.cmd_v = 1'b0;
                                    end
                                end else if (opc8 == `FIS_OP_SUSP_A || opc8 == `FIS_OP_SUSP_B) begin
                                    if (r.st == SS_IDLE && op_running_i && !r.nested &&
                                        op_kind_i != OK_OTHER) begin
                                        n.st = SS_LAT;
                                        n.lat = 13'd0;
                                        n.skind = op_kind_i;
                                        n.saddr = op_addr_i;
                                        n.sus_pulse = 1'b1;
                                    end else begin
                                        n.cmd_v = 1'b0;
                                    end
                                end else if (opc8 == `FIS_OP_RES_A || opc8 == `FIS_OP_RES_B) begin
                                    if (r.st == SS_HELD && !op_running_i) begin
                                        n.st = SS_IDLE;
                                        n.write_enable_latch = 1'b1;
                                        n.write_in_progress = 1'b1;
                                        n.sus_pgm = 1'b0;
                                        n.sus_ers = 1'b0;
                                        n.res_pulse = 1'b1;
                                    end else begin
                                        n.cmd_v = 1'b0;
                                    end
                                end else if (opc8 == `FIS_OP_WRITE_ENABLE_CMD) begin
                                    n.write_enable_latch = 1'b1; // set wins over a same cycle done
                                end else if (opc8 == `FIS_OP_WRITE_DISABLE_CMD) begin
                                    n.write_enable_latch = 1'b0;
                                end
                            end
                        end
                    end
                end
                PH_QPRE: begin
                    if (rise) begin
                        n.cnt = 4'(r.cnt + 4'd1);
                        if (r.cnt == `FIS_QADDR_HI) begin
                            n.qaddr[7:4] = r.io_s2;
                        end
                        if (r.cnt == `FIS_QADDR_LO) begin
                            n.qaddr[3:0] = r.io_s2;
                        end
                        if (r.cnt == `FIS_QPRE_LAST) begin
                            sh_if.load = 1'b1;
                            sh_if.quad = 1'b1;
                            sh_if.pattern = {first_id, second_id, 8'h00};
                            n.id_quad = 1'b1;
                            n.phase = PH_OUT;
                        end
                    end
                end
                PH_OUT: begin
                    if (fall) begin
                        sh_if.step = 1'b1;
                        n.oe = r.id_quad ? 4'hf : 4'h2;
                    end
                end
                PH_IGN: begin
                end
            endcase
        end

        n.rd_blk = (r.sus_pgm | r.sus_ers) &&
                   region_hit(r.skind, r.saddr, array_read_addr_i);
        n.pg_ok = !r.sus_ers ||
                  (!program_protected_i && !region_hit(r.skind, r.saddr, program_addr_i));
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
            // idle chip select is high, so the synchroniser starts deselected
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
        end else begin
            r <= n;
        end
    end

    always_comb begin
        status_word_o = 16'h0000;
        status_word_o[`FIS_SR_SUS_PGM] = r.sus_pgm;
        status_word_o[`FIS_SR_SUS_ERS] = r.sus_ers;
        status_word_o[`FIS_SR_WEL] = r.write_enable_latch;
        status_word_o[`FIS_SR_WIP] = r.write_in_progress;
    end

    assign spi_io_o                 = sh_if.dout;
    assign spi_io_oe_o              = r.oe;
    assign op_suspend_o             = r.sus_pulse;
    assign op_resume_o              = r.res_pulse;
    assign cmd_valid_o              = r.cmd_v;
    assign cmd_code_o               = r.cmd;
    assign write_enable_latch_o     = r.write_enable_latch;
    assign write_in_progress_o      = r.write_in_progress;
    assign program_suspended_flag_o = r.sus_pgm;
    assign erase_suspended_flag_o   = r.sus_ers;
    assign read_blocked_o           = r.rd_blk;
    assign program_permit_o         = r.pg_ok;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_quad_needs_qe: assert property ((r.phase != PH_QPRE) ##1 (r.phase == PH_QPRE)
        |-> $past(quad_io_enable_bit_i))
        else $error("quad id read entered with quad enable low");

    a_ident_not_busy: assert property ($rose(r.phase == PH_OUT) && !r.id_quad
        |-> $past(op_running_i) == 1'b0)
        else $error("ident read decoded while a cycle runs");

    a_cs_ends_out: assert property (r.cs_s2 |=> (r.phase == PH_OPC) && (r.oe == 4'h0))
        else $error("output not ended by deselect");

    a_latency_done: assert property ($rose(r.st == SS_HELD)
        |-> ($past(r.lat) == lat_last(r.skind)) && !r.write_enable_latch && (r.sus_pgm != r.sus_ers))
        else $error("suspend took effect at the wrong time");

    a_flag_bits: assert property ((r.st == SS_IDLE) |-> !status_word_o[15] && !status_word_o[10])
        else $error("suspend flag shown while not suspended");

    a_resume_sets: assert property ((r.st == SS_HELD) ##1 (r.st == SS_IDLE)
        |-> r.write_enable_latch && r.write_in_progress && !r.sus_pgm && !r.sus_ers && op_resume_o)
        else $error("resume did not update latch, busy and flags");

    a_susp_needs_op: assert property (op_suspend_o |-> $past(op_running_i) && !$past(r.nested))
        else $error("suspend issued with nothing suspendable running");

    a_pgm_erase_only: assert property (cmd_valid_o && cmd_code_o inside {`FIS_OP_PP, `FIS_OP_WRITE_ENABLE_CMD}
        |-> !r.sus_pgm)
        else $error("program command taken during a program suspend");

    a_read_block: assert property (read_blocked_o |-> $past(r.sus_pgm || r.sus_ers))
        else $error("read blocked outside a suspend");

    a_suspend_starts: assert property (op_suspend_o |-> (r.st == SS_LAT) && (r.lat == 13'd0))
        else $error("suspend pulse without a fresh latency count");

    a_latency_cmds: assert property (cmd_valid_o && ($past(r.st) == SS_LAT)
        |-> cmd_code_o inside {`FIS_OP_WRITE_DISABLE_CMD, `FIS_OP_STAT_LO, `FIS_OP_STAT_HI,
                               `FIS_OP_STAT_IRQ, `FIS_OP_RST_ARM, `FIS_OP_RST, `FIS_OP_NOP})
        else $error("command outside the no wait set taken during suspend latency");

    a_resume_idle: assert property (op_resume_o |-> !$past(op_running_i) && ($past(r.st) == SS_HELD))
        else $error("resume taken while a program runs or nothing is suspended");

    a_nested_busy: assert property (r.nested |-> r.write_in_progress && r.sus_ers)
        else $error("program inside an erase suspend not shown as busy");
endmodule

// [verif/fis_host_model.sv]
// host model: spi master that frames commands and collects id output
module fis_host_model (
    output logic            sck_o,
    output logic            cs_n_o,
    output logic [3:0]      io_o,
    output logic [3:0]      io_oe_o,
    input  wire logic [3:0] io_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
        io_oe_o = 4'h0;
    end
    // serial clock stands still outside frames; data changes only after a falling edge
    task automatic xfer(input logic [7:0] op, input bit quad, input logic [7:0] adr, input int nrd,
                        output logic [31:0] rd);
        logic [47:0] pre;
        pre = {16'h0000, adr, 8'h00, 16'h0000};
        rd = '0;
        cs_n_o = 1'b0;
        #40;
        io_oe_o = 4'h1;
        for (int i = 7; i >= 0; i--) begin
            io_o[0] = op[i];
            #80 sck_o = 1'b1;
            #80 sck_o = 1'b0;
        end
        if (quad) begin
            io_oe_o = 4'hf;
            for (int i = 11; i >= 0; i--) begin
                io_o = pre[i*4 +: 4];
                #80 sck_o = 1'b1;
                #80 sck_o = 1'b0;
            end
        end
        io_oe_o = 4'h0;
        for (int i = 0; i < nrd; i++) begin
            #80 sck_o = 1'b1;
            rd = quad ? {rd[27:0], io_i} : {rd[30:0], io_i[1]};
            #80 sck_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        #80;
    endtask
endmodule

// [verif/fis_top_test.sv]
// self-checking bench for the id read and suspend control block
module fis_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import fis_pkg::*;
    // arbitrary id values
    localparam logic [7:0] MFR = 8'hc1, DEV = 8'h2d, TYP = 8'h3e, CAP = 8'h4f;
    logic clock_i = 1'b0, rst_n_i = 1'b0, qe = 1'b0, run = 1'b0, done = 1'b0, prot = 1'b0;
    fis_op_kind_e kind = OK_OTHER;
    logic [23:0] op_addr = '0, rd_addr = '0, pg_addr = '0;
    logic sck, cs_n, susp, resm, cv, write_enable_latch, write_in_progress, sp, se, rb, pp;
    logic [3:0] h_io, h_oe, d_io, d_oe, oe_seen, junk = 4'h5;
    logic [7:0] code;
    logic [15:0] sw, res_sw;
    logic [31:0] rd;
    int failures = 0, cmp_count = 0, nv = 0, nsus = 0, nres = 0;
    // an undriven line toggles, so a stale value can never pass as output
    wire [3:0] io = (h_io & h_oe) | (d_io & d_oe) | (junk & ~h_oe & ~d_oe);
    fis_top #(.MFR_CODE(MFR), .DEV_CODE(DEV), .MEM_TYPE(TYP), .CAP_CODE(CAP)) i_fis_top (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_io_i(io),
        .spi_io_o(d_io), .spi_io_oe_o(d_oe), .quad_io_enable_bit_i(qe), .op_running_i(run),
        .op_kind_i(kind), .op_addr_i(op_addr), .op_done_i(done), .array_read_addr_i(rd_addr),
        .program_addr_i(pg_addr), .program_protected_i(prot), .op_suspend_o(susp), .op_resume_o(resm),
        .cmd_valid_o(cv), .cmd_code_o(code), .write_enable_latch_o(write_enable_latch), .write_in_progress_o(write_in_progress),
        .program_suspended_flag_o(sp), .erase_suspended_flag_o(se), .status_word_o(sw),
        .read_blocked_o(rb), .program_permit_o(pp));
    fis_host_model i_fis_host_model (.sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .io_oe_o(h_oe), .io_i(io));
    initial forever #2.5 clock_i = ~clock_i;
    // monitors sample mid-cycle, away from the edge that launches the outputs
    always @(negedge clock_i) begin
        junk <= ~junk;
        nv += cv;
        nsus += susp;
        nres += resm;
        oe_seen |= d_oe;
        if (resm === 1'b1) res_sw = sw;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic frame(input logic [7:0] op, input bit quad = 0, input logic [7:0] adr = 8'h00);
        nv = 0;
        nsus = 0;
        nres = 0;
        oe_seen = 4'h0;
        res_sw = 16'h0000;
        i_fis_host_model.xfer(op, quad, adr, quad ? 8 : 32, rd);
        wait_cyc(8);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic t_ident();
        frame(8'h9f);
        chk(nv, 1);
        chk(code, 8'h9f);
        chk(rd, {MFR, TYP, CAP, MFR});
        chk(oe_seen, 4'h2);
        chk(d_oe, 4'h0);
        run = 1'b1;
        frame(8'h9f);
        chk({nv[3:0], oe_seen}, 8'h00);
        run = 1'b0;
    endtask
    task automatic t_quad();
        frame(8'h94, 1);
        chk({nv[3:0], oe_seen}, 8'h00);
        qe = 1'b1;
        frame(8'h94, 1);
        chk(rd, {MFR, DEV, MFR, DEV});
        chk(oe_seen, 4'hf);
        frame(8'h94, 1, 8'h01);
        chk(rd, {DEV, MFR, DEV, MFR});
        frame(8'h75);
        chk(nsus, 0);
    endtask
    task automatic t_erase();
        run = 1'b1;
        kind = OK_SECTOR_ERASE;
        op_addr = 24'h012345;
        frame(8'h75);
        chk(nsus, 1);
        run = 1'b0;
        frame(8'h05);
        chk(nv, 1);
        frame(8'h03);
        chk(nv, 0);
        // suspend latency of 4000 cycles, fixed by the design's settings
        wait_cyc(4100);
        chk({sw[15], sw[10], sw[1]}, 3'b010);
        rd_addr = 24'h012fff;
        pg_addr = 24'h012800;
        wait_cyc(3);
        chk({rb, pp}, 2'b10);
        rd_addr = 24'h013000;
        pg_addr = 24'h020000;
        wait_cyc(3);
        chk({rb, pp}, 2'b01);
        prot = 1'b1;
        wait_cyc(3);
        chk(pp, 1'b0);
        prot = 1'b0;
        frame(8'h03);
        chk(nv, 1);
        frame(8'hd8);
        chk({nv[3:0], se}, 5'h01);
        frame(8'h06);
        chk({nv[3:0], write_enable_latch}, 5'h03);
        frame(8'h02);
        chk({nv[3:0], code}, 12'h102);
        run = 1'b1;
        wait_cyc(3);
        chk({write_enable_latch, write_in_progress}, 2'b11);
        frame(8'h75);
        chk(nsus, 0);
        frame(8'h7a);
        chk({nres[3:0], se}, 5'h01);
        done = 1'b1;
        wait_cyc(1);
        done = 1'b0;
        run = 1'b0;
        wait_cyc(2);
        chk({write_enable_latch, write_in_progress, se}, 3'b001);
        frame(8'h7a);
        chk(nres, 1);
        chk(res_sw, 16'h0003);
        run = 1'b1;
        wait_cyc(4);
        done = 1'b1;
        wait_cyc(1);
        done = 1'b0;
        run = 1'b0;
    endtask
    task automatic t_prog();
        run = 1'b1;
        kind = OK_PAGE_PROG;
        op_addr = 24'h030140;
        frame(8'hb0);
        chk(nsus, 1);
        run = 1'b0;
        wait_cyc(4100);
        chk({sw[15], sw[10], sw[1]}, 3'b100);
        chk({sp, se}, 2'b10);
        rd_addr = 24'h0301ff;
        wait_cyc(3);
        chk(rb, 1'b1);
        frame(8'h06);
        chk(nv, 0);
        frame(8'h04);
        chk(nv, 1);
        frame(8'h30);
        chk(nres, 1);
        chk(res_sw, 16'h0003);
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        wait_cyc(4);
        t_ident();
        t_quad();
        t_erase();
        t_prog();
        conclude();
    end
    initial begin
        #400000;
        failures++;
        conclude();
    end
endmodule
